// *** hw/sram_consts.svh ***
// Purpose: Constants for the pipelined burst synchronous SRAM access logic
// Assumes: Included by bare name; definitions only
// Notes:   Widths are defaults, modules take them as parameters
`ifndef SRAM_CONSTS_SVH
`define SRAM_CONSTS_SVH

`define SRAM_ADDR_W      16
`define SRAM_BYTES       4
`define SRAM_BYTE_W      9
`define SRAM_BURST_W     2
`define SRAM_BYTES_ALL   4'hF
`define SRAM_ORDER_LIN   1'h0
`define SRAM_ORDER_INTLV 1'h1

`endif

// *** hw/sram_pkg.sv ***
// Purpose: Types for the pipelined burst synchronous SRAM access logic
// Assumes: Nothing
// Notes:   Access kinds recorded per cycle
package sram_pkg;

  typedef enum logic [1:0]
  {
    ACC_IDLE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b10
  } acc_kind_e;

endpackage : sram_pkg

// *** hw/burst_counter.sv ***
// Purpose: Two-bit wraparound burst address counter
// Assumes: Order input held static during operation
// Notes:   Tracks step count, derives the address from start and order
`include "sram_consts.svh"

module burst_counter #(
  parameter int BW = `SRAM_BURST_W
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          load_i,
  input  wire logic [BW-1:0] start_i,
  input  wire logic          step_i,
  input  wire logic          order_i,
  output logic      [BW-1:0] addr_o
);

  logic [BW-1:0] start_q;
  logic [BW-1:0] step_q;
  logic [BW-1:0] step_n;

  // Advance takes effect in its own cycle
  assign step_n = BW'(step_q + BW'(step_i));

  // ------------------------------------------------------------
  // Start and step registers
  // ------------------------------------------------------------
  // Load captures low address bits; advance steps the sequence
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      start_q <= '0;
      step_q  <= '0;
    end
    else if (load_i)
    begin
      start_q <= start_i;
      step_q  <= '0;
    end
    else
    begin
      step_q <= step_n;
    end
  end

  // Interleaved is xor with step, linear is add modulo four
  always_comb
  begin
    if (order_i == `SRAM_ORDER_INTLV)
      addr_o = start_q ^ step_n;
    else
      addr_o = BW'(start_q + step_n);
  end

endmodule : burst_counter

// *** hw/sync_burst_sram.sv ***
// Purpose: Access logic and array of a pipelined burst SRAM, output released the cycle after deselect
// Assumes: All inputs synchronous to clk_i except output enable
// Notes:   Data pin split into input, output and enable
`include "sram_consts.svh"

module sync_burst_sram #(
  parameter int AW     = `SRAM_ADDR_W,
  parameter int NBYTES = `SRAM_BYTES,
  parameter int BYTE_W = `SRAM_BYTE_W
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic [AW-1:0]            addr_i,
  input  wire logic                     processor_addr_strobe_n_i,
  input  wire logic                     controller_addr_strobe_n_i,
  input  wire logic                     burst_advance_n_i,
  input  wire logic                     global_write_n_i,
  input  wire logic                     byte_write_enable_n_i,
  input  wire logic [NBYTES-1:0]        byte_select_n_i,
  input  wire logic                     chip_sel_a_n_i,
  input  wire logic                     chip_sel_b_i,
  input  wire logic                     chip_sel_c_n_i,
  input  wire logic                     output_enable_n_i,
  input  wire logic                     burst_order_i,
  input  wire logic [NBYTES*BYTE_W-1:0] dq_i,
  output logic      [NBYTES*BYTE_W-1:0] dq_o,
  output logic                          dq_oe_o
);

  localparam int DW    = NBYTES * BYTE_W;
  localparam int DEPTH = 1 << AW;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // Byte lanes written by a given write-enable combination
  function automatic logic [NBYTES-1:0] lanes(input logic gw_n, input logic bwe_n,
                                              input logic [NBYTES-1:0] bs_n);
    if (!gw_n)
      lanes = {NBYTES{1'b1}};
    else if (!bwe_n)
      lanes = ~bs_n;
    else
      lanes = '0;
  endfunction : lanes

  // Merge selected lanes of new data into old word
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w,
                                          input logic [DW-1:0] new_w,
                                          input logic [NBYTES-1:0] en);
    merge = old_w;
    for (int b = 0; b < NBYTES; b++)
      if (en[b])
        merge[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
  endfunction : merge

  // ------------------------------------------------------------
  // Input registers
  // ------------------------------------------------------------
  logic [AW-1:0]     addr_in_q;
  logic              processor_addr_strobe_n_n_q;
  logic              controller_addr_strobe_n_n_q;
  logic              adv_n_q;
  logic              gw_n_q;
  logic              bwe_n_q;
  logic [NBYTES-1:0] bs_n_q;
  logic              cs_a_n_q;
  logic              cs_b_q;
  logic              cs_c_n_q;
  logic [DW-1:0]     din_q;
  logic              order_q;

  // Capture every synchronous input on the rising edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_in_q <= '0;
      processor_addr_strobe_n_n_q  <= 1'b1;
      controller_addr_strobe_n_n_q  <= 1'b1;
      adv_n_q   <= 1'b1;
      gw_n_q    <= 1'b1;
      bwe_n_q   <= 1'b1;
      bs_n_q    <= '1;
      cs_a_n_q  <= 1'b1;
      cs_b_q    <= 1'b0;
      cs_c_n_q  <= 1'b1;
      din_q     <= '0;
    end
    else
    begin
      addr_in_q <= addr_i;
      processor_addr_strobe_n_n_q  <= processor_addr_strobe_n_i;
      controller_addr_strobe_n_n_q  <= controller_addr_strobe_n_i;
      adv_n_q   <= burst_advance_n_i;
      gw_n_q    <= global_write_n_i;
      bwe_n_q   <= byte_write_enable_n_i;
      bs_n_q    <= byte_select_n_i;
      cs_a_n_q  <= chip_sel_a_n_i;
      cs_b_q    <= chip_sel_b_i;
      cs_c_n_q  <= chip_sel_c_n_i;
      din_q     <= dq_i;
    end
  end

  // Strap caught by a clocked process; pulled-up default is interleaved
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      order_q <= `SRAM_ORDER_INTLV;
    else
      order_q <= burst_order_i;
  end

  // ------------------------------------------------------------
  // Cycle decode on registered inputs
  // ------------------------------------------------------------
  logic              selected;
  logic              p_strobe;
  logic              c_strobe;
  logic              new_addr;
  logic              deselect;
  logic [NBYTES-1:0] wr_lanes;
  logic              wr_req;

  assign selected = !cs_a_n_q && cs_b_q && !cs_c_n_q;
  assign p_strobe = !processor_addr_strobe_n_n_q && !cs_a_n_q;
  assign c_strobe = !controller_addr_strobe_n_n_q && processor_addr_strobe_n_n_q;
  assign new_addr = p_strobe || c_strobe;
  assign deselect = new_addr && !selected;
  assign wr_lanes = lanes(gw_n_q, bwe_n_q, bs_n_q);
  assign wr_req   = |wr_lanes;

  // ------------------------------------------------------------
  // Burst state and address register
  // ------------------------------------------------------------
  logic [AW-1:0] base_q;
  logic          active_q;
  logic          pending_q;
  logic [1:0]    burst_lo;
  logic          start_acc;
  logic          step;

  assign start_acc = new_addr && selected;
  // Advance ignored on a strobe cycle, held when high
  assign step = !start_acc && active_q && !adv_n_q;

  // Address register loads on every strobe-initiated access
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      base_q <= '0;
    else if (start_acc)
      base_q <= addr_in_q;
  end

  // Burst active flag; processor strobe leaves a write pending
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      active_q  <= 1'b0;
      pending_q <= 1'b0;
    end
    else if (new_addr)
    begin
      active_q  <= selected;
      pending_q <= start_acc && p_strobe;
    end
    else
    begin
      pending_q <= 1'b0;
    end
  end

  burst_counter #(
    .BW (`SRAM_BURST_W)
  ) u_burst (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (start_acc),
    .start_i (addr_in_q[1:0]),
    .step_i  (step),
    .order_i (order_q),
    .addr_o  (burst_lo)
  );

  // Strobe cycle passes the new address straight to the array
  logic [AW-1:0] cur_addr;

  always_comb
  begin
    if (start_acc)
      cur_addr = addr_in_q;
    else
      cur_addr = {base_q[AW-1:2], burst_lo};
  end

  // ------------------------------------------------------------
  // Access kind of this cycle
  // ------------------------------------------------------------
  sram_pkg::acc_kind_e kind;

  always_comb
  begin
    if (start_acc && p_strobe)
      kind = sram_pkg::ACC_READ;
    else if (start_acc)
      kind = wr_req ? sram_pkg::ACC_WRITE : sram_pkg::ACC_READ;
    else if (active_q && !new_addr)
      kind = wr_req ? sram_pkg::ACC_WRITE : sram_pkg::ACC_READ;
    else
      kind = sram_pkg::ACC_IDLE;
  end

  // ------------------------------------------------------------
  // Memory array
  // ------------------------------------------------------------
  logic [DW-1:0] mem_q [DEPTH];

  // Self-timed write of the selected lanes
  always_ff @(posedge clk_i)
  begin
    if (kind == sram_pkg::ACC_WRITE)
      mem_q[cur_addr] <= merge(mem_q[cur_addr], din_q, wr_lanes);
  end

  // ------------------------------------------------------------
  // Output pipeline
  // ------------------------------------------------------------
  logic          rd_q;
  logic          first_q;
  logic          sel_out_q;
  logic [DW-1:0] dout_q;

  // Output register loads read data for the next edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dout_q <= '0;
      rd_q   <= 1'b0;
    end
    else
    begin
      rd_q <= (kind == sram_pkg::ACC_READ);
      if (kind == sram_pkg::ACC_READ)
        dout_q <= mem_q[cur_addr];
    end
  end

  // First cycle after emerging from deselect is masked
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      first_q <= 1'b0;
    else
      first_q <= start_acc && !active_q;
  end

  // Extra enable stage lags deselect by one cycle, but rd_q already gates the output off then
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sel_out_q <= 1'b0;
    else if (new_addr)
      sel_out_q <= selected || active_q;
    else
      sel_out_q <= active_q;
  end

  assign dq_o = dout_q;
  // Output enable is asynchronous; writes always release the bus
  assign dq_oe_o = rd_q && sel_out_q && !first_q && !output_enable_n_i
                   && (kind != sram_pkg::ACC_WRITE);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_WRITE_RELEASES: assert property (@(posedge clk_i) disable iff (rst_i)
    (kind == sram_pkg::ACC_WRITE) |-> !dq_oe_o)
    else $error("Data driven during write cycle");

  AST_OE_GATES: assert property (@(posedge clk_i) disable iff (rst_i)
    output_enable_n_i |-> !dq_oe_o)
    else $error("Data driven with output enable high");

  AST_FIRST_MASK: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_acc && !active_q) |=> !dq_oe_o)
    else $error("Data driven in first cycle after deselect");

  AST_P_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i)
    (cs_a_n_q && controller_addr_strobe_n_n_q) |-> !new_addr)
    else $error("Processor strobe taken with chip select high");

  AST_P_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    (p_strobe && selected) |-> (kind == sram_pkg::ACC_READ))
    else $error("Processor strobe first cycle not a read");

  AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (active_q && !new_addr && adv_n_q && !$past(start_acc)) |-> $stable(burst_lo))
    else $error("Burst address moved without advance");

  AST_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    start_acc ##1 !step |-> (base_q == $past(addr_in_q)) && (burst_lo == $past(addr_in_q[1:0])))
    else $error("Address register not loaded by strobe");

  AST_P_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    (pending_q && !new_addr && wr_req) |-> (kind == sram_pkg::ACC_WRITE))
    else $error("Processor strobe write not performed on second edge");

  AST_READ_PIPE: assert property (@(posedge clk_i) disable iff (rst_i)
    (kind == sram_pkg::ACC_READ) |=> rd_q && (dq_o == $past(mem_q[cur_addr])))
    else $error("Read data not in output register next edge");

  AST_C_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    (c_strobe && selected && wr_req) |-> (kind == sram_pkg::ACC_WRITE))
    else $error("Controller write not performed in strobe cycle");

endmodule : sync_burst_sram

// *** verif/host_bus_model.sv ***
// Purpose: Host side bus model driving the burst SRAM pins
// Assumes: One request per clock through task bus
// Notes:   Released data lines toggle every cycle
module host_bus_model #(
  parameter int AW = 6
) (
  input  wire logic          clk_i,
  output logic      [AW-1:0] addr_o,
  output logic      [5:0]    ctl_o,
  output logic      [3:0]    bs_n_o,
  output logic      [2:0]    cs_o,
  output logic               order_o,
  output logic      [35:0]   dq_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle and deselected at time zero
  initial
  begin
    addr_o = '0;
    ctl_o = 6'h2E;
    bs_n_o = 4'hF;
    cs_o = 3'h0;
    order_o = 1'h1;
    dq_o = 36'h0;
  end

  // One bus cycle; ctl is {p_n, c_n, adv_n, gw_n, bwe_n, oe_n}
  task automatic bus(input logic [5:0] c, input logic [AW-1:0] a, input logic [3:0] bs,
                     input logic [1:0] sel, input logic ord, input logic [35:0] d,
                     input logic drv, input logic rude);
    @(posedge clk_i);
    ctl_o <= {c[5:1], c[0] | (drv & ~rude)};
    addr_o <= a;
    bs_n_o <= bs;
    cs_o <= (sel == 2'h1) ? 3'h2 : ((sel == 2'h2) ? 3'h6 : 3'h0);
    order_o <= ord;
    dq_o <= drv ? d : ~dq_o;
  endtask : bus
endmodule : host_bus_model

// *** verif/test_sync_burst_sram.sv ***
// Purpose: Self-checking bench for the burst SRAM access logic
// Assumes: Read data shows two edges after the request
// Notes:   Expected values come from a behavioural memory model
module test_sync_burst_sram;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 6;
  typedef struct packed {logic cw; logic cd; logic co; logic eo; logic [35:0] d;} slot_s;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic [AW-1:0] addr;
  logic [5:0]    ctl;
  logic [3:0]    bs_n;
  logic [2:0]    cs;
  logic          ord = 1'b1;
  logic          strap;
  logic          oe;
  logic [35:0]   hdq;
  logic [35:0]   rdq;
  wire  [35:0]   dq_w;
  slot_s         c_q = '0;
  slot_s         s0_q = '0;
  slot_s         s1_q = '0;
  logic [35:0]   mem [0:63];
  int            num_errors = 0;
  int            n_tests = 0;
  int            cyc = 0;
  int            seed = 68;

  // Clock and shared data wire
  always #2 clk_i = ~clk_i;
  assign dq_w = oe ? rdq : hdq;

  host_bus_model #(.AW(AW)) hb (.clk_i(clk_i), .addr_o(addr), .ctl_o(ctl), .bs_n_o(bs_n),
    .cs_o(cs), .order_o(strap), .dq_o(hdq));

  sync_burst_sram #(.AW(AW)) uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr),
    .processor_addr_strobe_n_i(ctl[5]), .controller_addr_strobe_n_i(ctl[4]),
    .burst_advance_n_i(ctl[3]), .global_write_n_i(ctl[2]), .byte_write_enable_n_i(ctl[1]),
    .byte_select_n_i(bs_n), .chip_sel_a_n_i(cs[2]), .chip_sel_b_i(cs[1]),
    .chip_sel_c_n_i(cs[0]), .output_enable_n_i(ctl[0]), .burst_order_i(strap),
    .dq_i(dq_w), .dq_o(rdq), .dq_oe_o(oe));

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("errors=%0d comparisons=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // Expectation pipeline and cycle ceiling
  always @(posedge clk_i)
  begin
    s0_q <= c_q;
    s1_q <= s0_q;
    cyc <= cyc + 1;
    if (cyc > 1000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  // Compare outputs in mid cycle
  always @(negedge clk_i)
  begin
    if (s0_q.cw)
      chk({35'h0, oe}, 36'h0);
    if (s1_q.cd)
      chk(rdq, s1_q.d);
    if (s1_q.co)
      chk({35'h0, oe}, {35'h0, s1_q.eo});
  end

  task automatic go(input logic [5:0] c, input logic [AW-1:0] a, input logic [3:0] bs,
                    input logic [1:0] sel, input logic [35:0] d, input logic dv,
                    input logic rude, input slot_s e);
    hb.bus(c, a, bs, sel, ord, d, dv, rude);
    c_q <= e;
  endtask : go

  task automatic des;
    go(6'h2E, '0, 4'hF, 2'h0, '0, 1'b0, 1'b0, '0);
  endtask : des

  function automatic logic [35:0] rnd36;
    return 36'({$random(seed), $random(seed)});
  endfunction : rnd36

  // Single access, a write when enables ask for one; p starts it by processor strobe
  task automatic wcyc(input logic [AW-1:0] a, input logic gw, input logic byte_write_enable_n,
                      input logic [3:0] bs, input logic [35:0] d, input logic burst_advance_n,
                      input logic p, input logic [1:0] rude);
    logic w;
    int   b;
    w = !gw || (!byte_write_enable_n && bs !== 4'hF);
    if (p)
      go(6'h1F, a, 4'hF, 2'h1, '0, 1'b0, 1'b0, '{1'b0, 1'b1, 1'b0, 1'b0, mem[a]});
    go({1'b1, p, burst_advance_n, gw, byte_write_enable_n, w & !rude[0]}, p ? ~a : a, bs, p ? 2'h2 : 2'h1, d, w,
       rude[0], '{w, !w, rude[1], 1'b0, mem[a]});
    for (b = 0; b < 4; b++)
      if (!gw || (w && !bs[b]))
        mem[a][9*b+:9] = d[9*b+:9];
  endtask : wcyc

  // Four beat burst read, then a held beat under an ignored processor strobe
  task automatic burst(input logic [AW-1:0] a);
    logic [1:0] s;
    int         i;
    int         j;
    for (i = 0; i < 5; i++)
    begin
      j = (i > 3) ? 3 : i;
      s = ord ? (a[1:0] ^ 2'(j)) : (a[1:0] + 2'(j));
      go((i == 0) ? 6'h1A : ((i == 4) ? 6'h1E : 6'h36), (i == 4) ? ~a : a, 4'h0,
         (i == 0) ? 2'h1 : 2'h2, '0, 1'b0, 1'b0,
         '{1'b0, 1'b1, 1'b1, i != 0, mem[{a[AW-1:2], s}]});
    end
    go(6'h2E, '0, 4'hF, 2'h0, '0, 1'b0, 1'b0, '{1'b0, 1'b0, 1'b1, 1'b0, 36'h0});
    des();
  endtask : burst

  // Main sequence
  initial
  begin
    logic [AW-1:0] a;
    logic          p;
    int            i;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    des();
    des();
    for (i = 0; i < 16; i++)
      wcyc(AW'(i), 1'b0, 1'b1, 4'hF, rnd36(), 1'b1, 1'b0, 2'h0);
    for (i = 0; i < 24; i++)
    begin
      p = 1'($random(seed));
      wcyc(AW'($random(seed)) & 6'hF, 1'($random(seed)), 1'($random(seed)),
           4'($random(seed)), rnd36(), p | 1'($random(seed)), p, 2'h0);
    end
    for (i = 0; i < 8; i++)
    begin
      if (i % 4 == 0)
      begin
        ord = (i == 0) ? 1'b0 : 1'b1;
        des();
        des();
      end
      burst(AW'($random(seed)) & 6'hF);
    end
    a = AW'($random(seed)) & 6'hF;
    go(6'h0B, a, 4'h0, 2'h1, rnd36(), 1'b1, 1'b0, '{1'b0, 1'b1, 1'b0, 1'b0, mem[a]});
    go(6'h0B, a, 4'h0, 2'h1, rnd36(), 1'b1, 1'b0, '{1'b0, 1'b1, 1'b0, 1'b0, mem[a]});
    wcyc(a, 1'b0, 1'b1, 4'hF, rnd36(), 1'b1, 1'b0, 2'h3);
    wcyc(a ^ 6'h1, 1'b1, 1'b0, 4'h5, rnd36(), 1'b1, 1'b0, 2'h1);
    des();
    des();
    for (i = 0; i < 16; i++)
      wcyc(AW'(i), 1'b1, 1'b1, 4'hF, '0, 1'b1, 1'b0, 2'h0);
    des();
    des();
    des();
    give_verdict();
  end
endmodule : test_sync_burst_sram
